// ===== dv/pin_partner.sv
/*
  Outside world at the channel pins: an external level source beside the block.
  Assumes the bench sets the outside level and the block reports its drive enables.
*/
`timescale 1ns/1ps
module pin_partner
  import timer_pkg::*;
(
  // Levels and drive
  input  wire logic [NUM_CH-1:0] i_level,
  input  wire logic [NUM_CH-1:0] i_drv,
  input  wire logic [NUM_CH-1:0] i_oe_n,
  // Resolved pin
  output logic [NUM_CH-1:0]      o_line
);
  // Released pin shows the outside level
  assign o_line = (i_drv & ~i_oe_n) | (i_level & i_oe_n);
endmodule // pin_partner

// ===== dv/timer_pwm_module_tb.sv
/*
  Register-level bench for the timer: counter, compare, PWM and capture paths.
  Assumes the fixed clock enable steps the counter, one pulse per step.
*/
`timescale 1ns/1ps
module timer_pwm_module_tb;
  import timer_pkg::*;
  localparam bus_req_type IDLE = '0;
  logic              i_clk;
  logic              i_reset;
  bus_req_type       bus;
  logic [7:0]        rdata;
  logic              fix_en;
  logic              halt;
  logic              ext_clk;
  logic [NUM_CH-1:0] level;
  logic [NUM_CH-1:0] pin_in;
  logic [NUM_CH-1:0] pin_out;
  logic [NUM_CH-1:0] oe_n;
  logic              ovf_irq;
  logic [NUM_CH-1:0] ch_irq;
  int                errors;
  int                samples_checked;
  int                cycles;

  timer_pwm_module dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_bus(bus), .o_rdata(rdata),
    .i_fixed_clk_en(fix_en), .i_ext_clk(ext_clk), .i_debug_halt(halt),
    .i_pin(pin_in), .o_pin(pin_out), .o_pin_oe_n(oe_n),
    .o_overflow_irq(ovf_irq), .o_channel_irq(ch_irq)
  );
  pin_partner partner (.i_level(level), .i_drv(pin_out), .i_oe_n(oe_n), .o_line(pin_in));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got 0x%0h expected 0x%0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    bus <= IDLE;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    bus <= IDLE;
    #1;
    chk(rdata, exp);
  endtask

  // Steps of the counter, then time for the pin to follow
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge i_clk);
      fix_en <= 1'b1;
      @(posedge i_clk);
      fix_en <= 1'b0;
    end
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  task automatic setpin(input logic v);
    @(posedge i_clk);
    level[1] <= v;
    repeat (3) @(posedge i_clk);
  endtask

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    i_reset = 1'b1;
    bus = IDLE;
    fix_en = 1'b0;
    halt = 1'b0;
    ext_clk = 1'b0;
    level = '0;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    #1;
    chk(8'(oe_n), 8'h03);
    rd(ADDR_TSC, 8'h00);
    rd(5'h06, 8'h00);
    rd(5'h07, 8'h00);
    wr(ADDR_TSC, 8'h50);
    wr(ADDR_MODH, 8'h00);
    wr(ADDR_MODL, 8'h03);
    wr(ADDR_CNTL, 8'h00);
    tick(1);
    rd(ADDR_CNTH, 8'h00);
    tick(1);
    rd(ADDR_CNTL, 8'h01);
    rd(ADDR_CNTL, 8'h02);
    rd(ADDR_CNTH, 8'h00);
    @(posedge i_clk);
    halt <= 1'b1;
    tick(1);
    @(posedge i_clk);
    halt <= 1'b0;
    rd(ADDR_CNTL, 8'h02);
    rd(ADDR_CNTH, 8'h00);
    tick(2);
    chk(8'(ovf_irq), 8'h01);
    rd(ADDR_TSC, 8'hD0);
    wr(ADDR_TSC, 8'h50);
    #1;
    chk(8'(ovf_irq), 8'h00);
    tick(1);
    wr(ADDR_CNTH, 8'h55);
    rd(ADDR_CNTH, 8'h00);
    rd(ADDR_CNTL, 8'h00);
    // Compare on channel 0, value 2, period 4
    wr(5'h05, 8'h14);
    rd(5'h05, 8'h14);
    wr(5'h07, 8'h02);
    rd(5'h07, 8'h00);
    wr(5'h06, 8'h00);
    rd(5'h07, 8'h02);
    tick(3);
    chk(8'(pin_out[0]), 8'h01);
    chk(8'(oe_n[0]), 8'h00);
    rd(5'h05, 8'h94);
    wr(5'h05, 8'h18);
    tick(4);
    chk(8'(pin_out[0]), 8'h00);
    rd(5'h05, 8'h98);
    wr(5'h05, 8'h1C);
    tick(4);
    chk(8'(pin_out[0]), 8'h01);
    rd(5'h05, 8'h9C);
    wr(5'h05, 8'h5C);
    #1;
    chk(8'(ch_irq), 8'h00);
    tick(4);
    chk(8'(ch_irq), 8'h01);
    rd(5'h05, 8'hDC);
    // Edge PWM, high-true then low-true
    wr(5'h05, 8'h28);
    tick(1);
    chk(8'(pin_out[0]), 8'h01);
    tick(2);
    chk(8'(pin_out[0]), 8'h01);
    tick(1);
    chk(8'(pin_out[0]), 8'h00);
    wr(5'h05, 8'h24);
    tick(1);
    chk(8'(pin_out[0]), 8'h00);
    tick(3);
    chk(8'(pin_out[0]), 8'h01);
    // Capture on channel 1, pin held steady before the switch
    wr(5'h08, 8'h04);
    rd(5'h08, 8'h04);
    setpin(1'b1);
    chk(8'(oe_n[1]), 8'h01);
    rd(5'h08, 8'h84);
    rd(5'h09, 8'h00);
    tick(1);
    setpin(1'b0);
    setpin(1'b1);
    rd(5'h0A, 8'h03);
    rd(5'h0A, 8'h00);
    rd(5'h09, 8'h00);
    wr(5'h08, 8'h08);
    tick(1);
    setpin(1'b0);
    rd(5'h0A, 8'h01);
    rd(5'h09, 8'h00);
    // Center mode: 0,1,2,3 then down
    rd(ADDR_TSC, 8'hD0);
    wr(ADDR_TSC, 8'h30);
    wr(ADDR_CNTL, 8'h00);
    rd(ADDR_TSC, 8'h30);
    tick(4);
    chk(8'(pin_out), 8'h01);
    rd(ADDR_CNTL, 8'h02);
    rd(ADDR_CNTH, 8'h00);
    rd(ADDR_TSC, 8'hB0);
    tick(3);
    chk(8'(pin_out), 8'h02);
    rd(ADDR_CNTL, 8'h01);
    rd(ADDR_CNTH, 8'h00);
    wr(5'h05, 8'h20);
    #1;
    chk(8'(oe_n[0]), 8'h01);
    // External clock at a quarter of the bus rate
    wr(ADDR_TSC, 8'h18);
    wr(ADDR_CNTL, 8'h00);
    repeat (3) begin
      @(posedge i_clk);
      ext_clk <= 1'b1;
      repeat (2) @(posedge i_clk);
      ext_clk <= 1'b0;
      @(posedge i_clk);
    end
    repeat (2) @(posedge i_clk);
    rd(ADDR_CNTH, 8'h00);
    rd(ADDR_CNTL, 8'h03);
    // Bus clock for two cycles, then off
    wr(ADDR_CNTL, 8'h00);
    wr(ADDR_TSC, 8'h08);
    wr(ADDR_TSC, 8'h00);
    rd(ADDR_CNTH, 8'h00);
    rd(ADDR_CNTL, 8'h02);
    // Paired value write, high byte first
    wr(5'h06, 8'h12);
    wr(5'h07, 8'h34);
    rd(5'h06, 8'h12);
    rd(5'h07, 8'h34);
    report_and_stop();
  end
endmodule // timer_pwm_module_tb

// ===== hdl/channel_pin_unit.sv
/*
  One timer channel's pin logic: capture edge detect, compare action and PWM levels.
  Assumes the pin is synchronous to i_clk and that the parent holds the value register.
*/
`timescale 1ns/1ps
module channel_pin_unit (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  // Configuration and counter view
  input  wire logic                   i_cpwm,
  input  wire timer_pkg::chan_cfg_type i_cfg,
  input  wire logic                   i_tick,
  input  wire logic                   i_count_up,
  input  wire logic                   i_overflow,
  input  wire logic [15:0]            i_count,
  input  wire logic [15:0]            i_value,
  // Pin
  input  wire logic                   i_pin,
  output logic                        o_pin,
  output logic                        o_pin_oe_n,
  // Event towards the flag
  output logic                        o_event
);
  import timer_pkg::*;

  pin_state_type q;
  pin_state_type d;
  logic          match;
  logic          rise;
  logic          fall;
  logic          inactive;

  always_comb begin
    d          = q;
    o_event    = 1'b0;
    d.pin_prev = i_pin;
    match      = i_tick && (i_count == i_value);
    rise       = i_pin & ~q.pin_prev;
    fall       = ~i_pin & q.pin_prev;
    inactive   = i_cfg.els[0];
    if (i_cpwm) begin
      if (i_cfg.els != ELS_OFF) begin
        if ((i_value == CNT_ZERO) || i_value[15]) begin
          d.out = inactive;
        end else if (match) begin
          o_event = 1'b1;
          d.out   = i_count_up ? inactive : ~inactive;
        end
      end
    end else if (i_cfg.mode[1]) begin
      if (i_cfg.els != ELS_OFF) begin
        if (i_overflow) begin
          d.out = (i_value == CNT_ZERO) ? inactive : ~inactive;
        end else if (match) begin
          d.out = inactive;
        end
        o_event = match;
      end
    end else if (i_cfg.mode == MS_COMPARE) begin
      o_event = match;
      if (match) begin
        unique case (i_cfg.els)
          ELS_OFF:   d.out = q.out;
          ELS_RISE:  d.out = ~q.out;
          ELS_CLEAR: d.out = 1'b0;
          ELS_SET:   d.out = 1'b1;
        endcase
      end
    end else begin
      o_event = (i_cfg.els[0] & rise) | (i_cfg.els[1] & fall);
    end
  end

  // Pin released when unused or sampled
  assign o_pin_oe_n = (i_cfg.els == ELS_OFF) || (!i_cpwm && i_cfg.mode == MS_CAPTURE);
  assign o_pin      = q.out;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  property p_capture_rise;
    @(posedge i_clk) disable iff (i_reset)
      !i_cpwm && i_cfg.mode == MS_CAPTURE && i_cfg.els == ELS_RISE && $rose(i_pin) |-> o_event;
  endproperty
  a_capture_rise: assert property (p_capture_rise) else $error("rising edge not captured");

  property p_compare_toggle;
    @(posedge i_clk) disable iff (i_reset)
      !i_cpwm && i_cfg.mode == MS_COMPARE && i_cfg.els == ELS_RISE && match |=> o_pin != $past(o_pin);
  endproperty
  a_compare_toggle: assert property (p_compare_toggle) else $error("compare did not toggle pin");

endmodule // channel_pin_unit

// ===== hdl/timer_pkg.sv
/*
  Shared constants, register map and carrier types for the timer/PWM block.
  Assumes an 8-bit register port with a 5-bit address and one 250 MHz clock.
*/
package timer_pkg;

  localparam int NUM_CH = 2;

  // Register map, byte addresses
  localparam logic [4:0] ADDR_TSC     = 5'h00;
  localparam logic [4:0] ADDR_CNTH    = 5'h01;
  localparam logic [4:0] ADDR_CNTL    = 5'h02;
  localparam logic [4:0] ADDR_MODH    = 5'h03;
  localparam logic [4:0] ADDR_MODL    = 5'h04;
  localparam int         CH_BASE      = 5;
  localparam int         CH_STRIDE    = 3;
  localparam int         CH_OFS_SC    = 0;
  localparam int         CH_OFS_VH    = 1;
  localparam int         CH_OFS_VL    = 2;

  // Timer control/status fields
  localparam int TSC_TOF   = 7;
  localparam int TSC_OVERFLOW_INTERRUPT_ENABLE  = 6;
  localparam int TSC_CPWM  = 5;
  localparam int TSC_CLK_H = 4;
  localparam int TSC_CLK_L = 3;

  // Channel control/status fields
  localparam int CSC_FLAG  = 7;
  localparam int CSC_CFG_H = 6;
  localparam int CSC_CFG_L = 2;

  localparam logic [1:0]  CLK_OFF     = 2'h0;
  localparam logic [1:0]  CLK_BUS     = 2'h1;
  localparam logic [1:0]  CLK_FIXED   = 2'h2;
  localparam logic [1:0]  CLK_EXT     = 2'h3;
  localparam logic [1:0]  ELS_OFF     = 2'h0;
  localparam logic [1:0]  ELS_RISE    = 2'h1;
  localparam logic [1:0]  ELS_CLEAR   = 2'h2;
  localparam logic [1:0]  ELS_SET     = 2'h3;
  localparam logic [1:0]  MS_CAPTURE  = 2'h0;
  localparam logic [1:0]  MS_COMPARE  = 2'h1;
  localparam logic [15:0] CNT_ZERO    = 16'h0000;
  localparam logic [15:0] CNT_ONE     = 16'h0001;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } bus_req_type;

  typedef struct packed {
    logic       ie;
    logic [1:0] mode;
    logic [1:0] els;
  } chan_cfg_type;

  typedef struct packed {
    logic pin_prev;
    logic out;
  } pin_state_type;

  typedef struct packed {
    chan_cfg_type cfg;
    logic         flag;
    logic         armed;
    logic [15:0]  value;
    logic [7:0]   buf_hi;
    logic [7:0]   buf_lo;
    logic         got_hi;
    logic         got_lo;
    logic [15:0]  rlat;
    logic         rlat_valid;
    logic         rlat_first_hi;
  } chan_state_type;

  typedef struct packed {
    chan_state_type [NUM_CH-1:0] ch;
    logic [15:0] count;
    logic        dir_down;
    logic        counter_overflow_flag;
    logic        tof_armed;
    logic        overflow_interrupt_enable;
    logic        cpwm;
    logic [1:0]  clksel;
    logic [15:0] modv;
    logic [7:0]  mod_buf_hi;
    logic [7:0]  mod_buf_lo;
    logic        mod_got_hi;
    logic        mod_got_lo;
    logic [15:0] cnt_lat;
    logic        cnt_lat_valid;
    logic        cnt_lat_first_hi;
    logic        ext_prev;
    logic [7:0]  rdata;
  } timer_state_type;

  function automatic logic [4:0] ch_addr(input int n, input int ofs);
    return 5'(CH_BASE + n * CH_STRIDE + ofs);
  endfunction

endpackage

// ===== hdl/timer_pwm_module.sv
/*
  16-bit timer with capture, compare, edge and center PWM channels and 8-bit registers.
  Assumes one 250 MHz clock, synchronous pins and a one-cycle read/write strobe port.
*/
`timescale 1ns/1ps
module timer_pwm_module (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_reset,
  // Register port
  input  wire timer_pkg::bus_req_type   i_bus,
  output logic [7:0]                    o_rdata,
  // Count sources and mode
  input  wire logic                     i_fixed_clk_en,
  input  wire logic                     i_ext_clk,
  input  wire logic                     i_debug_halt,
  // Channel pins
  input  wire logic [timer_pkg::NUM_CH-1:0] i_pin,
  output logic [timer_pkg::NUM_CH-1:0]  o_pin,
  output logic [timer_pkg::NUM_CH-1:0]  o_pin_oe_n,
  // Requests
  output logic                          o_overflow_irq,
  output logic [timer_pkg::NUM_CH-1:0]  o_channel_irq
);
  import timer_pkg::*;

  timer_state_type     q;
  timer_state_type     d;
  logic                tick;
  logic                ovf;
  logic                cnt_wr;
  logic [15:0]         term;
  logic [NUM_CH-1:0]   ch_event;
  logic                capture;

  assign cnt_wr = i_bus.wr && (i_bus.addr == ADDR_CNTH || i_bus.addr == ADDR_CNTL);

  always_comb begin
    d          = q;
    d.rdata    = BYTE_ZERO;
    d.ext_prev = i_ext_clk;
    ovf        = 1'b0;
    capture    = 1'b0;
    unique case (q.clksel)
      CLK_OFF:   tick = 1'b0;
      CLK_BUS:   tick = 1'b1;
      CLK_FIXED: tick = i_fixed_clk_en;
      CLK_EXT:   tick = i_ext_clk & ~q.ext_prev;
    endcase
    if (i_debug_halt) begin
      tick = 1'b0;
    end
    term = (q.modv == CNT_ZERO) ? CNT_MAX : q.modv;

    // Main counter
    if (cnt_wr) begin
      d.count         = CNT_ZERO;
      d.dir_down      = 1'b0;
      d.cnt_lat_valid = 1'b0;
    end else if (tick) begin
      if (!q.cpwm) begin
        if (q.count == term) begin
          d.count = CNT_ZERO;
          ovf     = 1'b1;
        end else begin
          d.count = q.count + CNT_ONE;
        end
      end else if (!q.dir_down) begin
        if (q.count == q.modv) begin
          d.dir_down = 1'b1;
          d.count    = q.count - CNT_ONE;
          ovf        = 1'b1;
        end else begin
          d.count = q.count + CNT_ONE;
        end
      end else begin
        if (q.count == CNT_ZERO) begin
          d.dir_down = 1'b0;
          d.count    = q.count + CNT_ONE;
        end else begin
          d.count = q.count - CNT_ONE;
        end
      end
    end

    // Timer control/status
    if (i_bus.rd && i_bus.addr == ADDR_TSC) begin
      d.rdata[TSC_TOF]               = q.counter_overflow_flag;
      d.rdata[TSC_OVERFLOW_INTERRUPT_ENABLE]              = q.overflow_interrupt_enable;
      d.rdata[TSC_CPWM]              = q.cpwm;
      d.rdata[TSC_CLK_H:TSC_CLK_L]   = q.clksel;
      if (q.counter_overflow_flag) begin
        d.tof_armed = 1'b1;
      end
    end
    if (i_bus.wr && i_bus.addr == ADDR_TSC) begin
      d.overflow_interrupt_enable       = i_bus.wdata[TSC_OVERFLOW_INTERRUPT_ENABLE];
      d.cpwm       = i_bus.wdata[TSC_CPWM];
      d.clksel     = i_bus.wdata[TSC_CLK_H:TSC_CLK_L];
      d.mod_got_hi = 1'b0;
      d.mod_got_lo = 1'b0;
      d.tof_armed  = 1'b0;
      if (!i_bus.wdata[TSC_TOF] && q.tof_armed) begin
        d.counter_overflow_flag = 1'b0;
      end
    end
    if (ovf) begin
      d.counter_overflow_flag       = 1'b1;
      d.tof_armed = 1'b0;
    end

    // Counter reads, coherent pair
    if (i_bus.rd && (i_bus.addr == ADDR_CNTH || i_bus.addr == ADDR_CNTL)) begin
      if (!q.cnt_lat_valid) begin
        d.cnt_lat          = q.count;
        d.cnt_lat_valid    = 1'b1;
        d.cnt_lat_first_hi = (i_bus.addr == ADDR_CNTH);
        d.rdata            = (i_bus.addr == ADDR_CNTH) ? q.count[15:8] : q.count[7:0];
      end else begin
        d.rdata = (i_bus.addr == ADDR_CNTH) ? q.cnt_lat[15:8] : q.cnt_lat[7:0];
        if (q.cnt_lat_first_hi != (i_bus.addr == ADDR_CNTH)) begin
          d.cnt_lat_valid = 1'b0;
        end
      end
    end

    // Modulus, paired bytes
    if (i_bus.rd && i_bus.addr == ADDR_MODH) begin
      d.rdata = q.modv[15:8];
    end
    if (i_bus.rd && i_bus.addr == ADDR_MODL) begin
      d.rdata = q.modv[7:0];
    end
    if (i_bus.wr && i_bus.addr == ADDR_MODH) begin
      if (q.mod_got_lo) begin
        d.modv       = {i_bus.wdata, q.mod_buf_lo};
        d.mod_got_lo = 1'b0;
      end else begin
        d.mod_buf_hi = i_bus.wdata;
        d.mod_got_hi = 1'b1;
      end
    end
    if (i_bus.wr && i_bus.addr == ADDR_MODL) begin
      if (q.mod_got_hi) begin
        d.modv       = {q.mod_buf_hi, i_bus.wdata};
        d.mod_got_hi = 1'b0;
      end else begin
        d.mod_buf_lo = i_bus.wdata;
        d.mod_got_lo = 1'b1;
      end
    end

    // Channels
    for (int n = 0; n < NUM_CH; n++) begin
      capture = !q.cpwm && q.ch[n].cfg.mode == MS_CAPTURE;
      if (i_bus.rd && i_bus.addr == ch_addr(n, CH_OFS_SC)) begin
        d.rdata[CSC_FLAG]            = q.ch[n].flag;
        d.rdata[CSC_CFG_H:CSC_CFG_L] = q.ch[n].cfg;
        if (q.ch[n].flag) begin
          d.ch[n].armed = 1'b1;
        end
      end
      if (i_bus.wr && i_bus.addr == ch_addr(n, CH_OFS_SC)) begin
        d.ch[n].cfg        = i_bus.wdata[CSC_CFG_H:CSC_CFG_L];
        d.ch[n].armed      = 1'b0;
        d.ch[n].got_hi     = 1'b0;
        d.ch[n].got_lo     = 1'b0;
        d.ch[n].rlat_valid = 1'b0;
        if (!i_bus.wdata[CSC_FLAG] && q.ch[n].armed) begin
          d.ch[n].flag = 1'b0;
        end
      end
      if (i_bus.rd && (i_bus.addr == ch_addr(n, CH_OFS_VH) || i_bus.addr == ch_addr(n, CH_OFS_VL))) begin
        if (!capture) begin
          d.rdata = (i_bus.addr == ch_addr(n, CH_OFS_VH)) ? q.ch[n].value[15:8] : q.ch[n].value[7:0];
        end else if (!q.ch[n].rlat_valid) begin
          d.ch[n].rlat          = q.ch[n].value;
          d.ch[n].rlat_valid    = 1'b1;
          d.ch[n].rlat_first_hi = (i_bus.addr == ch_addr(n, CH_OFS_VH));
          d.rdata = (i_bus.addr == ch_addr(n, CH_OFS_VH)) ? q.ch[n].value[15:8] : q.ch[n].value[7:0];
        end else begin
          d.rdata = (i_bus.addr == ch_addr(n, CH_OFS_VH)) ? q.ch[n].rlat[15:8] : q.ch[n].rlat[7:0];
          if (q.ch[n].rlat_first_hi != (i_bus.addr == ch_addr(n, CH_OFS_VH))) begin
            d.ch[n].rlat_valid = 1'b0;
          end
        end
      end
      if (i_bus.wr && i_bus.addr == ch_addr(n, CH_OFS_VH)) begin
        if (q.ch[n].got_lo) begin
          d.ch[n].value  = {i_bus.wdata, q.ch[n].buf_lo};
          d.ch[n].got_lo = 1'b0;
        end else begin
          d.ch[n].buf_hi = i_bus.wdata;
          d.ch[n].got_hi = 1'b1;
        end
      end
      if (i_bus.wr && i_bus.addr == ch_addr(n, CH_OFS_VL)) begin
        if (q.ch[n].got_hi) begin
          d.ch[n].value  = {q.ch[n].buf_hi, i_bus.wdata};
          d.ch[n].got_hi = 1'b0;
        end else begin
          d.ch[n].buf_lo = i_bus.wdata;
          d.ch[n].got_lo = 1'b1;
        end
      end
      // Event after bus handling so a new event beats a clear
      if (ch_event[n]) begin
        d.ch[n].flag  = 1'b1;
        d.ch[n].armed = 1'b0;
        if (capture) begin
          d.ch[n].value = q.count;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      channel_pin_unit u_pin (
        .i_clk      (i_clk),
        .i_reset    (i_reset),
        .i_cpwm     (q.cpwm),
        .i_cfg      (q.ch[g].cfg),
        .i_tick     (tick && !cnt_wr),
        .i_count_up (!q.dir_down),
        .i_overflow (ovf),
        .i_count    (q.count),
        .i_value    (q.ch[g].value),
        .i_pin      (i_pin[g]),
        .o_pin      (o_pin[g]),
        .o_pin_oe_n (o_pin_oe_n[g]),
        .o_event    (ch_event[g])
      );
      assign o_channel_irq[g] = q.ch[g].flag & q.ch[g].cfg.ie;
    end
  endgenerate

  assign o_overflow_irq = q.counter_overflow_flag & q.overflow_interrupt_enable;
  assign o_rdata        = q.rdata;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  property p_off_holds;
    q.clksel == CLK_OFF && !cnt_wr |=> $stable(q.count);
  endproperty
  a_off_holds: assert property (p_off_holds) else $error("counter moved with clock off");

  property p_halt_holds;
    i_debug_halt && !cnt_wr |=> $stable(q.count);
  endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("counter moved in debug halt");

  property p_up_step;
    !q.cpwm && tick && !cnt_wr && q.count != term |=> q.count == $past(q.count) + CNT_ONE;
  endproperty
  a_up_step: assert property (p_up_step) else $error("up count did not step by one");

  property p_up_wrap;
    !q.cpwm && tick && !cnt_wr && q.count == term |=> q.count == CNT_ZERO && q.counter_overflow_flag;
  endproperty
  a_up_wrap: assert property (p_up_wrap) else $error("wrap or overflow flag wrong");

  sequence s_at_top;
    q.cpwm && tick && !cnt_wr && !q.dir_down && q.count == q.modv && q.modv != CNT_ZERO;
  endsequence
  property p_top_turn;
    s_at_top |=> q.dir_down && q.counter_overflow_flag && q.count == $past(q.modv) - CNT_ONE;
  endproperty
  a_top_turn: assert property (p_top_turn) else $error("top turn wrong");

  property p_bottom_turn;
    q.cpwm && tick && !cnt_wr && q.dir_down && q.count == CNT_ZERO |=> !q.dir_down && q.count == CNT_ONE;
  endproperty
  a_bottom_turn: assert property (p_bottom_turn) else $error("bottom turn wrong");

  property p_cnt_reset;
    cnt_wr |=> q.count == CNT_ZERO && !q.cnt_lat_valid;
  endproperty
  a_cnt_reset: assert property (p_cnt_reset) else $error("counter write did not reset");

  sequence s_cnt_hi_fresh;
    i_bus.rd && i_bus.addr == ADDR_CNTH && !q.cnt_lat_valid;
  endsequence
  sequence s_cnt_lo;
    i_bus.rd && i_bus.addr == ADDR_CNTL;
  endsequence
  // One idle bus cycle between strobes
  sequence s_bus_quiet;
    !i_bus.wr && !i_bus.rd;
  endsequence
  property p_cnt_coherent;
    s_cnt_hi_fresh ##1 s_bus_quiet ##1 s_cnt_lo |=> o_rdata == $past(q.count[7:0], 3);
  endproperty
  a_cnt_coherent: assert property (p_cnt_coherent) else $error("counter pair not coherent");

  sequence s_flag_seen;
    i_bus.rd && i_bus.addr == ch_addr(0, CH_OFS_SC) && q.ch[0].flag && !ch_event[0];
  endsequence
  sequence s_quiet_no_event;
    !i_bus.wr && !i_bus.rd && !ch_event[0];
  endsequence
  sequence s_zero_write;
    i_bus.wr && i_bus.addr == ch_addr(0, CH_OFS_SC) && !i_bus.wdata[CSC_FLAG] && !ch_event[0];
  endsequence
  property p_flag_clear;
    s_flag_seen ##1 s_quiet_no_event ##1 s_zero_write |=> !q.ch[0].flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear sequence failed");

  property p_flag_set;
    ch_event[0] |=> q.ch[0].flag ##0 o_channel_irq[0] == q.ch[0].cfg.ie;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event lost or request wrong");

  sequence s_hi_first;
    i_bus.wr && i_bus.addr == ch_addr(0, CH_OFS_VH) && !q.ch[0].got_hi && !q.ch[0].got_lo;
  endsequence
  sequence s_lo_second;
    i_bus.wr && i_bus.addr == ch_addr(0, CH_OFS_VL) && !ch_event[0];
  endsequence
  property p_value_pair;
    s_hi_first ##1 s_bus_quiet ##1 s_lo_second |=> q.ch[0].value == {$past(i_bus.wdata, 3), $past(i_bus.wdata)};
  endproperty
  a_value_pair: assert property (p_value_pair) else $error("paired value write wrong");

endmodule // timer_pwm_module
